//--- rmw_defines.svh
`ifndef RMW_DEFINES_SVH
`define RMW_DEFINES_SVH

// Register offsets on the plain register port
`define RMW_ADDR_W 4
`define RMW_OFS_STATUS 4'h0
`define RMW_OFS_CONTROL 4'h1
`define RMW_OFS_TIMEOUT 4'h2

// reset_cause_status fields
`define RMW_ST_SLEEP 7
`define RMW_ST_FLAGS_LSB 1
`define RMW_FLAG_W 5
`define RMW_FLAG_BAD_ADDR 4
`define RMW_FLAG_TIMEOUT 3
`define RMW_FLAG_PORT_COMBO 2
`define RMW_FLAG_PIN 1
`define RMW_FLAG_PIN_WAKE 0
`define RMW_FLAGS_RESET 5'h00

// reset_source_control fields
`define RMW_CT_SLEEP_UNLOCK 7
`define RMW_CT_PORT_CFG 6
`define RMW_CT_BAD_ADDR 5
`define RMW_CT_TIMEOUT 4
`define RMW_CTRL_RESET 4'h0

// timeout_key_count
`define RMW_KEY_FIRST 8'h0a
`define RMW_KEY_SECOND 8'h03
`define RMW_WD_W 4
`define RMW_WD_LIMIT 4'h8
`define RMW_WD_RESET 4'h0

// Timing
`define RMW_CLK_NS 50
`define RMW_POR_MIN_MS 5
`define RMW_POR_MAX_MS 20
`define RMW_PIN_MIN_US 20
`define RMW_PIN_MAX_US 200
`define RMW_TIMEOUT_PERIOD_S 2
`define RMW_POR_CYC ((`RMW_POR_MIN_MS * 1000000 + `RMW_CLK_NS - 1) / `RMW_CLK_NS)
`define RMW_PIN_CYC ((`RMW_PIN_MIN_US * 1000 + `RMW_CLK_NS - 1) / `RMW_CLK_NS)
`define RMW_SRC_HOLD_CYC 16

`endif

//--- rmw_pkg.sv
`default_nettype none
package rmw_pkg;
    typedef logic [7:0] rmw_byte_t;
    typedef enum logic [2:0] {
        RMW_PWR_WAIT = 3'b001,
        RMW_PWR_HOLD = 3'b010,
        RMW_PWR_RUN = 3'b100
    } rmw_pwr_state_t;
endpackage
`default_nettype wire

//--- rmw_sync_if.sv
`default_nettype none
interface rmw_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

//--- rmw_sync3.sv
`default_nettype none
module rmw_sync3 #(
    parameter int W = 1
) (
    input wire logic i_clk,     // System clock
    input wire logic i_rstn,    // Async reset, active low
    rmw_sync_if.sync port       // Raw in, filtered out
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_clean;

    // A change counts only once stages two and three agree
    assign next_clean = (ff2 & ~(ff2 ^ ff3)) | (port.clean & (ff2 ^ ff3));

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            port.clean <= '0;
        end else begin
            ff1 <= port.raw;
            ff2 <= ff1;
            ff3 <= ff2;
            port.clean <= next_clean;
        end
    end
endmodule // rmw_sync3
`default_nettype wire

//--- rmw_reset_manager.sv
`include "rmw_defines.svh"
`default_nettype none

// Function
// R01: Power-up reset asserts on supply rise, releases only after regulator started.
// R02: Power-up reset held 5 to 20 ms before software runs.
// R03: High level on reset pin puts device into reset.
// R04: Reset held a version-dependent time after reset pin falls.
// R05: Port A combination request is a system reset source.
// R06: Enabled watchdog expiring without clear causes system reset.
// R07: Enabled bad-address access causes system reset.
// R08: Sleep entered by writing sleep bit while unlocked; sleep reset held throughout.
// R09: Sleep bit writes ignored while locked; sleep bit reads zero.
// R10: Distinct cause flag per reset source, including pin during sleep.
// R11: Cause flags accumulate until any write to status clears all.
// R12: Pin wake from sleep sets both pin flag and pin-wake flag.
// R13: Power-up leaves all cause flags zero.
// R14: Watchdog enable cannot be cleared by software; only power-up clears.
// R15: With port-config enable, port, bad-address, watchdog resets also reset ports.
// R16: Watchdog cleared only by consecutive writes 0x0a then 0x03.
// R17: Any other watchdog write between keys prevents the clear.
// R18: Four-bit readable watchdog counts 0 to 7, resets on reaching 8; a disabled watchdog here holds 8 until the next tick, then wraps to 0.
// R19: Software clears watchdog within 2 s; timeout at least 2 s.
// R20: Watchdog clocked by low prescaler, stops on external clock without RC.
// R21: System reset follows power-up or any enabled source; cold follows power-up only.
// R22: Port-config enable clear keeps port configuration through non-power-up resets; the pin reset here still resets port configuration.
// R23: Watchdog advances once per fixed low-prescaler tick; valid keys zero it.
// R24: Async requests synchronised before flags; system reset released synchronously.
module rmw_reset_manager #(
    parameter int unsigned P_POR_CYC = `RMW_POR_CYC,
    parameter int unsigned P_PIN_HOLD_CYC = `RMW_PIN_CYC,
    parameter int unsigned P_SRC_HOLD_CYC = `RMW_SRC_HOLD_CYC
) (
    input wire logic i_ref_clk,                    // 20 MHz system clock
    input wire logic i_rstn,                       // Power-on detector, active low
    input wire logic i_regulator_ready,            // Regulator started, async
    input wire logic i_reset_pin,                  // External reset pin, high = reset
    input wire logic i_port_combo_req,             // Port A combination request, async
    input wire logic i_bad_address,                // Access outside memory map, pulse
    input wire logic i_lowpre_tick,                // Low prescaler watchdog tick, pulse
    input wire logic i_ext_clk_used,               // External clock selected
    input wire logic i_rc_osc_enable,              // RC oscillator enabled
    input wire logic [`RMW_ADDR_W-1:0] i_addr,     // Register address
    input wire logic [7:0] i_wdata,                // Write data
    input wire logic i_wr,                         // Write strobe
    input wire logic i_rd,                         // Read strobe
    output logic [7:0] o_rdata,                    // Read data, cycle after strobe
    output logic o_reset_cold,                     // Power-up reset, high active
    output logic o_reset_system,                   // System-wide reset, high active
    output logic o_reset_port_cfg,                 // Port configuration reset
    output logic o_reset_sleep,                    // Sleep-hold reset
    output logic o_sleep                           // Device in sleep
);
    localparam int POR_W = $clog2(P_POR_CYC + 1);
    localparam int HOLD_MAX = (P_PIN_HOLD_CYC > P_SRC_HOLD_CYC) ?
        P_PIN_HOLD_CYC : P_SRC_HOLD_CYC;
    localparam int HOLD_W = $clog2(HOLD_MAX + 1);

    // Synchronisers for the asynchronous inputs
    // Agreement of two stages costs a cycle but rejects one-cycle glitches
    rmw_sync_if #(.W(3)) u_sync_if ();

    logic regulator_ok;
    logic pin_high;
    logic port_req;

    assign u_sync_if.raw = {i_regulator_ready, i_reset_pin, i_port_combo_req}; // [R24]
    assign regulator_ok = u_sync_if.clean[2];
    assign pin_high = u_sync_if.clean[1];
    assign port_req = u_sync_if.clean[0];

    rmw_sync3 #(
        .W(3)
    ) u_sync (
        .i_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .port(u_sync_if.sync)
    );

    // Power-up sequencing
    rmw_pkg::rmw_pwr_state_t pwr_state;
    rmw_pkg::rmw_pwr_state_t next_pwr_state;
    logic [POR_W-1:0] por_cnt;
    logic [POR_W-1:0] next_por_cnt;
    logic por_done;
    logic cold;
    logic next_cold;

    assign por_done = (por_cnt == POR_W'(P_POR_CYC - 1));

    always_comb begin
        next_pwr_state = pwr_state;
        next_por_cnt = por_cnt;
        case (pwr_state)
            rmw_pkg::RMW_PWR_WAIT: begin
                // Hold count starts only after the regulator is up
                next_por_cnt = '0;
                if (regulator_ok) begin
                    next_pwr_state = rmw_pkg::RMW_PWR_HOLD; // [R01]
                end
            end
            rmw_pkg::RMW_PWR_HOLD: begin
                if (por_done) begin
                    next_pwr_state = rmw_pkg::RMW_PWR_RUN; // [R02]
                end else begin
                    next_por_cnt = por_cnt + POR_W'(1);
                end
            end
            rmw_pkg::RMW_PWR_RUN: begin
                next_pwr_state = rmw_pkg::RMW_PWR_RUN;
            end
            default: begin
                next_pwr_state = rmw_pkg::RMW_PWR_WAIT;
                next_por_cnt = '0;
            end
        endcase
    end

    assign cold = (pwr_state != rmw_pkg::RMW_PWR_RUN);
    assign next_cold = (next_pwr_state != rmw_pkg::RMW_PWR_RUN); // [R21]

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pwr_state <= rmw_pkg::RMW_PWR_WAIT;
            por_cnt <= '0;
        end else begin
            pwr_state <= next_pwr_state;
            por_cnt <= next_por_cnt;
        end
    end

    // Register decode
    logic sel_status;
    logic sel_control;
    logic sel_timeout;
    logic wr_status;
    logic wr_control;
    logic wr_timeout;

    assign sel_status = (i_addr == `RMW_OFS_STATUS);
    assign sel_control = (i_addr == `RMW_OFS_CONTROL);
    assign sel_timeout = (i_addr == `RMW_OFS_TIMEOUT);
    // Software is not running during power-up, so writes are dropped then
    assign wr_status = i_wr & sel_status & ~cold;
    assign wr_control = i_wr & sel_control & ~cold;
    assign wr_timeout = i_wr & sel_timeout & ~cold;

    // Control register
    logic sleep_unlock;
    logic port_cfg_reset_enable;
    logic bad_address_reset_enable;
    logic timeout_reset_enable;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sleep_unlock <= 1'b0;
            port_cfg_reset_enable <= 1'b0;
            bad_address_reset_enable <= 1'b0;
            timeout_reset_enable <= 1'b0;
        end else if (cold) begin
            sleep_unlock <= 1'b0;
            port_cfg_reset_enable <= 1'b0;
            bad_address_reset_enable <= 1'b0;
            timeout_reset_enable <= 1'b0; // [R14]
        end else if (wr_control) begin
            sleep_unlock <= i_wdata[`RMW_CT_SLEEP_UNLOCK];
            port_cfg_reset_enable <= i_wdata[`RMW_CT_PORT_CFG];
            bad_address_reset_enable <= i_wdata[`RMW_CT_BAD_ADDR];
            // Once set, stays set until the next power-up
            timeout_reset_enable <= timeout_reset_enable | i_wdata[`RMW_CT_TIMEOUT]; // [R14]
        end
    end

    // Watchdog
    logic [`RMW_WD_W-1:0] wd_count;
    logic [`RMW_WD_W-1:0] next_wd_count;
    logic key_armed;
    logic next_key_armed;
    logic key_clear;
    logic wd_tick;
    logic wd_at_limit;
    logic wd_fire;

    // Clock stops when an external clock runs without the RC oscillator
    assign wd_tick = i_lowpre_tick & ~(i_ext_clk_used & ~i_rc_osc_enable); // [R20] [R23]
    assign wd_at_limit = (wd_count == `RMW_WD_LIMIT);
    // Level source: it stays up until the system reset clears the count
    assign wd_fire = wd_at_limit & timeout_reset_enable & ~cold; // [R06] [R18]
    assign key_clear = wr_timeout & key_armed & (i_wdata == `RMW_KEY_SECOND); // [R16]
    // Every watchdog write re-evaluates the arm, so a stray write disarms
    assign next_key_armed = wr_timeout ? (i_wdata == `RMW_KEY_FIRST) : key_armed; // [R17]

    always_comb begin
        next_wd_count = wd_count;
        if (key_clear) begin
            next_wd_count = `RMW_WD_RESET; // [R23]
        end else if (wd_tick) begin
            if (wd_at_limit) begin
                // Disabled watchdog wraps instead of firing
                next_wd_count = `RMW_WD_RESET;
            end else begin
                next_wd_count = wd_count + `RMW_WD_W'(1); // [R18]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wd_count <= `RMW_WD_RESET;
            key_armed <= 1'b0;
        end else if (cold || o_reset_system) begin
            wd_count <= `RMW_WD_RESET;
            key_armed <= 1'b0;
        end else begin
            wd_count <= next_wd_count;
            key_armed <= next_key_armed;
        end
    end

    // Reset sources and hold timer
    logic port_event;
    logic bad_event;
    logic src_event;
    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;
    logic hold_busy;
    logic by_pin;
    logic next_by_pin;
    logic next_system;
    logic next_port_cfg;

    assign port_event = port_req & ~cold; // [R05]
    assign bad_event = i_bad_address & bad_address_reset_enable & ~cold; // [R07]
    assign src_event = port_event | bad_event | wd_fire;
    assign hold_busy = (hold_cnt != '0);

    always_comb begin
        next_hold_cnt = hold_cnt;
        if (pin_high) begin
            // Hold time counts from the falling edge of the pin
            next_hold_cnt = HOLD_W'(P_PIN_HOLD_CYC); // [R03] [R04]
        end else if (src_event && (hold_cnt < HOLD_W'(P_SRC_HOLD_CYC))) begin
            next_hold_cnt = HOLD_W'(P_SRC_HOLD_CYC);
        end else if (hold_busy) begin
            next_hold_cnt = hold_cnt - HOLD_W'(1);
        end
    end

    // Remembers a pin reset so its hold time also resets the ports
    assign next_by_pin = pin_high | (by_pin & hold_busy);
    assign next_system = next_cold | pin_high | src_event | hold_busy; // [R21] [R24]
    // Power-up and pin resets always clear ports; other sources only when enabled
    assign next_port_cfg = next_cold | pin_high | (by_pin & hold_busy) |
        (next_system & port_cfg_reset_enable); // [R15] [R22]

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold_cnt <= '0;
            by_pin <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            by_pin <= next_by_pin;
        end
    end

    // Sleep control
    logic sleep_req;
    logic next_sleep;

    assign sleep_req = wr_status & i_wdata[`RMW_ST_SLEEP] & sleep_unlock; // [R08] [R09]
    // Any system reset wakes the device
    assign next_sleep = ~next_system & (o_sleep | sleep_req); // [R08]

    // Cause flags
    logic [`RMW_FLAG_W-1:0] flags;
    logic [`RMW_FLAG_W-1:0] flag_set;
    logic [`RMW_FLAG_W-1:0] next_flags;

    always_comb begin
        flag_set = '0;
        flag_set[`RMW_FLAG_BAD_ADDR] = bad_event; // [R10]
        flag_set[`RMW_FLAG_TIMEOUT] = wd_fire; // [R10]
        flag_set[`RMW_FLAG_PORT_COMBO] = port_event; // [R10]
        flag_set[`RMW_FLAG_PIN] = pin_high & ~cold; // [R10] [R12]
        flag_set[`RMW_FLAG_PIN_WAKE] = pin_high & o_sleep & ~cold; // [R12]
    end

    // Set wins over a clearing write in the same cycle
    assign next_flags = (wr_status ? `RMW_FLAGS_RESET : flags) | flag_set; // [R11]

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags <= `RMW_FLAGS_RESET;
        end else if (cold) begin
            flags <= `RMW_FLAGS_RESET; // [R13]
        end else begin
            flags <= next_flags; // [R11]
        end
    end

    // Reset outputs, all registered so release is synchronous
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reset_cold <= 1'b1;
            o_reset_system <= 1'b1;
            o_reset_port_cfg <= 1'b1;
            o_reset_sleep <= 1'b1;
            o_sleep <= 1'b0;
        end else begin
            o_reset_cold <= next_cold; // [R01]
            o_reset_system <= next_system; // [R21] [R24]
            o_reset_port_cfg <= next_port_cfg;
            o_reset_sleep <= next_cold | next_sleep; // [R08]
            o_sleep <= next_sleep;
        end
    end

    // Read path
    rmw_pkg::rmw_byte_t status_view;
    rmw_pkg::rmw_byte_t control_view;
    rmw_pkg::rmw_byte_t timeout_view;
    rmw_pkg::rmw_byte_t read_mux;

    // Sleep bit always reads as zero
    assign status_view = {1'b0, 1'b0, flags, 1'b0}; // [R09]
    assign control_view = {sleep_unlock, port_cfg_reset_enable,
        bad_address_reset_enable, timeout_reset_enable, `RMW_CTRL_RESET};
    assign timeout_view = {4'h0, wd_count}; // [R18]
    // Unmapped addresses read zero so software sees no alias
    assign read_mux = sel_status ? status_view :
        sel_control ? control_view :
        sel_timeout ? timeout_view : 8'h00;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? read_mux : 8'h00;
        end
    end
endmodule // rmw_reset_manager
`default_nettype wire

//--- rmw_reset_manager_asserts.sv
`include "rmw_defines.svh"
`default_nettype none
module rmw_reset_manager_asserts #(
    parameter int unsigned P_POR_CYC = 20
) (
    input wire logic i_ref_clk, // Clock
    input wire logic i_rstn, // Power-on
    input wire logic i_regulator_ready, // Regulator up
    input wire logic i_reset_pin, // Pin
    input wire logic i_port_combo_req, // Port request
    input wire logic i_bad_address, // Bad access
    input wire logic [`RMW_ADDR_W-1:0] i_addr, // Address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic [7:0] o_rdata, // Read data
    input wire logic o_reset_cold, // Cold reset
    input wire logic o_reset_system, // System reset
    input wire logic o_reset_port_cfg, // Port reset
    input wire logic o_reset_sleep, // Sleep reset
    input wire logic o_sleep // Sleep
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ctl;
    int unsigned rdy_cnt;
    wire logic ctl_wr = i_wr && i_addr == `RMW_OFS_CONTROL && !o_reset_cold;
    wire logic st_wr = i_wr && i_addr == `RMW_OFS_STATUS;

    // Shadow of unlock, port-config and bad-address enables
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl <= 3'h0;
        end else if (o_reset_cold) begin
            ctl <= 3'h0;
        end else if (ctl_wr) begin
            ctl <= i_wdata[7:5];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdy_cnt <= 0;
        end else if (!i_regulator_ready) begin
            rdy_cnt <= 0;
        end else if (rdy_cnt < P_POR_CYC + 8) begin
            rdy_cnt <= rdy_cnt + 1;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    a_cold_all: assert property (o_reset_cold |-> o_reset_system && o_reset_port_cfg
        && o_reset_sleep) else $error("cold reset without the other resets");
    a_por_hold: assert property ($fell(o_reset_cold) |-> rdy_cnt >= P_POR_CYC)
        else $error("cold reset released too early");
    a_pin_level: assert property (i_reset_pin [*6] |-> o_reset_system)
        else $error("pin high without system reset");
    a_port_level: assert property (i_port_combo_req [*6] |-> o_reset_system)
        else $error("port request without system reset");
    a_bad_addr: assert property (i_bad_address && ctl[0] && !o_reset_system
        && !i_reset_pin && !i_port_combo_req |=> o_reset_system && o_reset_port_cfg == ctl[1])
        else $error("bad address reset wrong");
    a_pcfg_en: assert property (o_reset_system && ctl[1] |-> o_reset_port_cfg)
        else $error("port config reset missing");
    a_sleep_enter: assert property (st_wr && i_wdata[7] && ctl[2] && !o_reset_system
        |=> o_sleep) else $error("sleep not entered");
    a_sleep_lock: assert property (st_wr && !ctl[2] && !o_sleep |=> !o_sleep)
        else $error("sleep entered while locked");
    a_sleep_hold: assert property (o_sleep |-> o_reset_sleep)
        else $error("sleep without sleep reset");
    a_wd_read: assert property ($past(i_rd) && $past(i_addr) == `RMW_OFS_TIMEOUT
        |-> o_rdata[7:4] == 4'h0 && o_rdata[3:0] <= `RMW_WD_LIMIT)
        else $error("watchdog read out of range");
endmodule // rmw_reset_manager_asserts

bind rmw_reset_manager rmw_reset_manager_asserts #(.P_POR_CYC(P_POR_CYC)) i_asserts (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_regulator_ready(i_regulator_ready),
    .i_reset_pin(i_reset_pin), .i_port_combo_req(i_port_combo_req),
    .i_bad_address(i_bad_address), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_reset_cold(o_reset_cold),
    .o_reset_system(o_reset_system), .o_reset_port_cfg(o_reset_port_cfg),
    .o_reset_sleep(o_reset_sleep), .o_sleep(o_sleep));
`default_nettype wire

//--- rmw_cpu_model.sv
`include "rmw_defines.svh"
`default_nettype none
module rmw_cpu_model (
    input wire logic i_ref_clk, // Clock
    input wire logic [7:0] i_rdata, // Read data
    output logic [`RMW_ADDR_W-1:0] o_addr, // Address
    output logic [7:0] o_wdata, // Write data
    output logic o_wr, // Write strobe
    output logic o_rd // Read strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr = '0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    task automatic wr(input logic [`RMW_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
    endtask

    task automatic rd(input logic [`RMW_ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
        @(posedge i_ref_clk);
        d = i_rdata;
    endtask

    // Software owes this pair within every timeout period
    task automatic kick();
        wr(`RMW_OFS_TIMEOUT, `RMW_KEY_FIRST);
        wr(`RMW_OFS_TIMEOUT, `RMW_KEY_SECOND);
    endtask
endmodule // rmw_cpu_model
`default_nettype wire

//--- rmw_reset_manager_tb.sv
`include "rmw_defines.svh"
`default_nettype none
module rmw_reset_manager_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned POR_CYC = 20;
    localparam int unsigned PIN_CYC = 8;
    typedef struct {logic [`RMW_ADDR_W-1:0] a; logic [7:0] d; logic [7:0] e;} rmw_row_t;
    logic clk, rstn, rdy, pin, combo, bad, tick, ext, rc, wr, rd;
    logic cold, sys, prst, srst, slp;
    logic [`RMW_ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata;
    int error_cnt = 0;
    int tests_run = 0;
    rmw_row_t rows [6] = '{'{`RMW_OFS_CONTROL, 8'h60, 8'h60},
        '{`RMW_OFS_CONTROL, 8'h1f, 8'h10}, '{`RMW_OFS_CONTROL, 8'h00, 8'h10},
        '{`RMW_OFS_STATUS, 8'hff, 8'h00}, '{`RMW_OFS_TIMEOUT, 8'h55, 8'h00},
        '{4'hf, 8'hff, 8'h00}};

    rmw_reset_manager #(.P_POR_CYC(POR_CYC), .P_PIN_HOLD_CYC(PIN_CYC), .P_SRC_HOLD_CYC(16))
    i_rmw_reset_manager (.i_ref_clk(clk), .i_rstn(rstn), .i_regulator_ready(rdy),
        .i_reset_pin(pin), .i_port_combo_req(combo), .i_bad_address(bad),
        .i_lowpre_tick(tick), .i_ext_clk_used(ext), .i_rc_osc_enable(rc), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_reset_cold(cold),
        .o_reset_system(sys), .o_reset_port_cfg(prst), .o_reset_sleep(srst), .o_sleep(slp));
    rmw_cpu_model i_cpu (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [`RMW_ADDR_W-1:0] a,
                          input logic [7:0] exp);
        logic [7:0] d;
        i_cpu.rd(a, d);
        chk(what, exp, d);
    endtask

    task automatic quiet();
        int n;
        n = 0;
        while (sys !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("system released", 8'h00, {7'h0, sys});
    endtask

    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask

    task automatic power_up();
        rstn <= 1'b0;
        rdy <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("cold before regulator", 8'h01, {7'h0, cold});
        chk("system during cold", 8'h01, {7'h0, sys});
        rdy <= 1'b1;
        repeat (POR_CYC) @(posedge clk);
        chk("cold hold", 8'h01, {7'h0, cold});
        repeat (10) @(posedge clk);
        chk("cold released", 8'h00, {7'h0, cold});
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    initial begin
        {pin, combo, bad, tick, ext} <= 5'h00;
        rc <= 1'b1;
        power_up();
        rd_chk("status at power-up", `RMW_OFS_STATUS, 8'h00);
        rd_chk("control at power-up", `RMW_OFS_CONTROL, 8'h00);
        foreach (rows[k]) begin
            i_cpu.wr(rows[k].a, rows[k].d);
            rd_chk("register row", rows[k].a, rows[k].e);
        end
        $display("Test registers done");
        i_cpu.wr(`RMW_OFS_CONTROL, 8'h80);
        i_cpu.wr(`RMW_OFS_STATUS, 8'h80);
        @(posedge clk);
        chk("sleep state", 8'h03, {6'h0, slp, srst});
        rd_chk("sleep bit", `RMW_OFS_STATUS, 8'h00);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("pin wake", 8'h02, {6'h0, sys, slp});
        pin <= 1'b0;
        repeat (PIN_CYC) @(posedge clk);
        chk("pin hold", 8'h01, {7'h0, sys});
        quiet();
        rd_chk("pin wake flags", `RMW_OFS_STATUS, 8'h06);
        combo <= 1'b1;
        repeat (6) @(posedge clk);
        chk("port reset", 8'h02, {6'h0, sys, prst});
        combo <= 1'b0;
        quiet();
        rd_chk("flags accumulate", `RMW_OFS_STATUS, 8'h0e);
        i_cpu.wr(`RMW_OFS_STATUS, 8'h00);
        rd_chk("flags cleared", `RMW_OFS_STATUS, 8'h00);
        $display("Test sleep and sources done");
        for (int k = 0; k < 2; k++) begin
            i_cpu.wr(`RMW_OFS_CONTROL, (k == 1) ? 8'h70 : 8'h30);
            bad <= 1'b1;
            @(posedge clk);
            bad <= 1'b0;
            repeat (3) @(posedge clk);
            chk("bad address reset", {6'h0, 1'b1, k[0]}, {6'h0, sys, prst});
            quiet();
        end
        rd_chk("bad address flag", `RMW_OFS_STATUS, 8'h20);
        i_cpu.wr(`RMW_OFS_STATUS, 8'h00);
        tick_n(3);
        i_cpu.wr(`RMW_OFS_TIMEOUT, `RMW_KEY_FIRST);
        i_cpu.wr(`RMW_OFS_TIMEOUT, 8'h05);
        i_cpu.wr(`RMW_OFS_TIMEOUT, `RMW_KEY_SECOND);
        rd_chk("broken key pair", `RMW_OFS_TIMEOUT, 8'h03);
        i_cpu.kick();
        rd_chk("key pair clears", `RMW_OFS_TIMEOUT, 8'h00);
        ext <= 1'b1;
        rc <= 1'b0;
        tick_n(2);
        rd_chk("stopped count", `RMW_OFS_TIMEOUT, 8'h00);
        ext <= 1'b0;
        rc <= 1'b1;
        tick_n(7);
        rd_chk("count of seven", `RMW_OFS_TIMEOUT, 8'h07);
        tick_n(1);
        repeat (4) @(posedge clk);
        chk("timeout reset", 8'h03, {6'h0, sys, prst});
        quiet();
        rd_chk("timeout flag", `RMW_OFS_STATUS, 8'h10);
        rd_chk("count after reset", `RMW_OFS_TIMEOUT, 8'h00);
        $display("Test faults and watchdog done");
        power_up();
        rd_chk("control after power-up", `RMW_OFS_CONTROL, 8'h00);
        rd_chk("status after power-up", `RMW_OFS_STATUS, 8'h00);
        bad <= 1'b1;
        @(posedge clk);
        bad <= 1'b0;
        repeat (3) @(posedge clk);
        chk("bad address disabled", 8'h00, {7'h0, sys});
        tick_n(10);
        rd_chk("count wraps when disabled", `RMW_OFS_TIMEOUT, 8'h01);
        rd_chk("no flag when disabled", `RMW_OFS_STATUS, 8'h00);
        $display("Test second power-up done");
        test_done();
    end
endmodule // rmw_reset_manager_tb
`default_nettype wire
